//--- core/lcs_cfg.svh
// offsets, field positions, reset values and timing counts for the line control block
`ifndef LCS_CFG_SVH
`define LCS_CFG_SVH
`define LCS_ADDR_W 12
`define LCS_OFF_LINE_CTRL 12'h112
`define LCS_OFF_COLL_CNT 12'h132
`define LCS_OFF_LINE_STAT 12'h134
`define LCS_OFF_IRQ_STAT 12'h140
`define LCS_OFF_IRQ_EN 12'h142
`define LCS_OFF_IRQ_CLR 12'h144
`define LCS_CTRL_RESET 16'h0013
`define LCS_CTRL_WMASK 16'h7FC0
`define LCS_COLL_ID 6'h12
`define LCS_STAT_ID 6'h14
`define LCS_TALLY_HALF 10'h1FF
`define LCS_TALLY_MAX 10'h3FF
`define LCS_CLK_HZ 40000000
`define LCS_BIT_NS 100
`define LCS_CRS_MIN_NS 130
`define LCS_CRS_MAX_NS 230
`define LCS_LINK_MS 50
`define LCS_IRQ_W 4
`endif

//--- core/lcs_pkg.sv
// types shared by the line control block
package lcs_pkg;
  typedef enum logic [1:0] {
    LCS_PORT_TP,
    LCS_PORT_AUI,
    LCS_PORT_AUTO
  } lcs_port_mode_e;

  typedef struct packed {
    logic rsvd_f;
    logic low_receive_squelch;
    logic two_part_deferral_disable;
    logic polarity_correction_disable;
    logic modified_backoff_enable;
    logic collision_overflow_irq_enable;
    logic auto_port_select;
    logic force_attachment_port;
    logic serial_transmit_enable;
    logic serial_receive_enable;
    logic [5:0] reg_id;
  } lcs_line_ctrl_s;

  typedef struct packed {
    logic tp_activity;
    logic tp_rx_data;
    logic tp_pol_reversed;
    logic aui_collision;
    logic aui_carrier;
  } lcs_line_in_s;
endpackage : lcs_pkg

//--- core/lcs_line_ctrl.sv
// line control, line status and transmit collision counter
// Function
// - tally steps when receive pair or AUI collision pair activates during transmit
// - tally occupies bits 6 to F of the collision counter register
// - with overflow enable and interrupt enable bit 0 set, interrupt as tally steps from 1FFh to 200h
// - tally wraps to zero after 3FFh
// - reading the collision counter returns tally then clears it
// - collision counter low six bits read 010010
// - line control resets to 0013h; strap may supply initial value
// - bit 8 forces AUI, both clear twisted pair, bit 9 auto
// - status bit 8 shows AUI in use
// - status bit 9 shows twisted pair in use
// - status bit C shows true incoming polarity regardless of disable
// - reversed receive data inverted unless polarity correction disabled
// - carrier sense bit E set while frame received until its end
// - carrier sense drops 1.3 to 2.3 bit times after last rising edge
// - link good clear after reset and after 50 ms without activity
// - line status low six bits read 010100
`timescale 1ns/1ps
`include "lcs_cfg.svh"
module lcs_line_ctrl
  import lcs_pkg::*;
#(
  parameter int unsigned LINK_CYC = (`LCS_CLK_HZ / 1000) * `LCS_LINK_MS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [`LCS_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic eeprom_present,
  input wire logic [15:0] eeprom_line_ctrl,
  input wire logic eeprom_valid,
  input wire lcs_line_in_s line_in,
  input wire logic tx_frame_req,
  input wire logic tx_active,
  input wire logic rx_frame_req,
  output logic tx_frame_start,
  output logic rx_frame_start,
  output logic rx_carrier,
  output logic rx_data_corr,
  output logic aui_select,
  output logic tp_select,
  output logic modified_backoff_sel,
  output logic single_part_deferral,
  output logic low_squelch_sel
);
  // bit-time figures in cycles; least rounds up, longest rounds down
  localparam int unsigned CRS_MIN_CYC =
    (`LCS_CRS_MIN_NS * (`LCS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CRS_MAX_CYC = (`LCS_CRS_MAX_NS * (`LCS_CLK_HZ / 1000000)) / 1000;
  localparam int unsigned CRS_CYC = CRS_MIN_CYC;
  localparam logic [3:0] CRS_LAST = 4'(CRS_CYC - 1);
  localparam logic [31:0] LINK_LAST = 32'(LINK_CYC - 1);

  lcs_line_ctrl_s ctrl_ff;
  logic [9:0] tally_ff;
  logic [`LCS_IRQ_W-1:0] irq_stat_ff;
  logic [`LCS_IRQ_W-1:0] irq_en_ff;
  logic strap_done_ff;
  logic coll_act_ff;
  logic tp_data_ff;
  logic [3:0] crs_cnt_ff;
  logic [31:0] link_cnt_ff;
  logic link_good_ff;
  logic rx_busy_ff;
  logic tx_busy_ff;
  lcs_port_mode_e port_mode;
  logic aui_now;
  logic coll_act;
  logic coll_step;
  logic crs_rise;
  logic rd_coll;
  logic [`LCS_IRQ_W-1:0] irq_evt;
  logic [15:0] coll_word;
  logic [15:0] stat_word;
  logic [15:0] nxt_rdata;

  // port mode decode
  always_comb begin
    if (ctrl_ff.force_attachment_port) begin
      port_mode = LCS_PORT_AUI;
    end else if (ctrl_ff.auto_port_select) begin
      port_mode = LCS_PORT_AUTO;
    end else begin
      port_mode = LCS_PORT_TP;
    end
  end

  // auto mode falls back to AUI only while the twisted-pair link is down
  always_comb begin
    case (port_mode)
      LCS_PORT_AUI: aui_now = 1'b1;
      LCS_PORT_AUTO: aui_now = ~link_good_ff;
      LCS_PORT_TP: aui_now = 1'b0;
      default: aui_now = 1'b0;
    endcase
  end

  assign coll_act = tx_active & (aui_now ? line_in.aui_collision : line_in.tp_activity);
  assign coll_step = coll_act & ~coll_act_ff;
  assign rd_coll = reg_rd & (reg_addr == `LCS_OFF_COLL_CNT);
  assign irq_evt = {3'h0, coll_step & (tally_ff == `LCS_TALLY_HALF)};

  // line control, optionally replaced once by the eeprom image after release
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `LCS_CTRL_RESET;
      strap_done_ff <= 1'b0;
    end else begin
      if (!strap_done_ff && eeprom_valid) begin
        strap_done_ff <= 1'b1;
        if (eeprom_present) begin
          ctrl_ff <= (eeprom_line_ctrl & `LCS_CTRL_WMASK) | `LCS_CTRL_RESET;
        end
      end else if (reg_wr && reg_addr == `LCS_OFF_LINE_CTRL) begin
        ctrl_ff <= (reg_wdata & `LCS_CTRL_WMASK) | 16'(`LCS_COLL_ID & 6'h00) | 16'h0013;
      end
    end
  end

  // collision tally; an increment in the read cycle lands after the clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tally_ff <= 10'h000;
      coll_act_ff <= 1'b0;
    end else begin
      coll_act_ff <= coll_act;
      if (rd_coll) begin
        tally_ff <= coll_step ? 10'h001 : 10'h000;
      end else if (coll_step) begin
        tally_ff <= tally_ff + 10'h001;
      end
    end
  end

  // sticky events, set beats clear
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
    end else begin
      if (reg_wr && reg_addr == `LCS_OFF_IRQ_EN) begin
        irq_en_ff <= reg_wdata[`LCS_IRQ_W-1:0];
      end
      if (reg_wr && reg_addr == `LCS_OFF_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`LCS_IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_ff & irq_en_ff) & ctrl_ff.collision_overflow_irq_enable;
    end
  end

  // carrier hold: restart on each rising edge of recovered data, or on each cycle of AUI carrier while AUI is in use
  assign crs_rise = line_in.tp_rx_data & ~tp_data_ff;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tp_data_ff <= 1'b0;
      crs_cnt_ff <= 4'h0;
      rx_carrier <= 1'b0;
    end else begin
      tp_data_ff <= line_in.tp_rx_data;
      if (aui_now ? line_in.aui_carrier : crs_rise) begin
        crs_cnt_ff <= CRS_LAST;
        rx_carrier <= 1'b1;
      end else if (crs_cnt_ff != 4'h0) begin
        crs_cnt_ff <= crs_cnt_ff - 4'h1;
      end else begin
        rx_carrier <= 1'b0;
      end
    end
  end

  // link watchdog; clear from reset until activity is seen
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      link_cnt_ff <= 32'h0000_0000;
      link_good_ff <= 1'b0;
    end else if (line_in.tp_activity) begin
      link_cnt_ff <= 32'h0000_0000;
      link_good_ff <= 1'b1;
    end else if (link_cnt_ff == LINK_LAST) begin
      link_good_ff <= 1'b0;
    end else begin
      link_cnt_ff <= link_cnt_ff + 32'h0000_0001;
    end
  end

  // frame gating: a frame in flight always completes
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_busy_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      rx_frame_start <= 1'b0;
      tx_frame_start <= 1'b0;
    end else begin
      rx_frame_start <= rx_frame_req & ~rx_busy_ff & ctrl_ff.serial_receive_enable;
      tx_frame_start <= tx_frame_req & ~tx_busy_ff & ctrl_ff.serial_transmit_enable;
      if (rx_frame_req && !rx_busy_ff && ctrl_ff.serial_receive_enable) begin
        rx_busy_ff <= 1'b1;
      end else if (!rx_carrier) begin
        rx_busy_ff <= 1'b0;
      end
      if (tx_frame_req && !tx_busy_ff && ctrl_ff.serial_transmit_enable) begin
        tx_busy_ff <= 1'b1;
      end else if (!tx_active && !tx_frame_req) begin
        tx_busy_ff <= 1'b0;
      end
    end
  end

  // physical-side selects
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aui_select <= 1'b0;
      tp_select <= 1'b0;
      rx_data_corr <= 1'b0;
      modified_backoff_sel <= 1'b0;
      single_part_deferral <= 1'b0;
      low_squelch_sel <= 1'b0;
    end else begin
      aui_select <= aui_now;
      tp_select <= ~aui_now;
      rx_data_corr <= line_in.tp_rx_data ^
        (line_in.tp_pol_reversed & ~ctrl_ff.polarity_correction_disable);
      modified_backoff_sel <= ctrl_ff.modified_backoff_enable;
      single_part_deferral <= ctrl_ff.two_part_deferral_disable;
      low_squelch_sel <= ctrl_ff.low_receive_squelch;
    end
  end

  assign coll_word = {tally_ff, `LCS_COLL_ID};
  assign stat_word = {1'b0, rx_carrier, 1'b0, ~line_in.tp_pol_reversed, 2'b00,
    ~aui_now, aui_now, link_good_ff, 1'b0, `LCS_STAT_ID};

  always_comb begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      `LCS_OFF_LINE_CTRL: nxt_rdata = ctrl_ff;
      `LCS_OFF_COLL_CNT: nxt_rdata = coll_word;
      `LCS_OFF_LINE_STAT: nxt_rdata = stat_word;
      `LCS_OFF_IRQ_STAT: nxt_rdata = {12'h000, irq_stat_ff};
      `LCS_OFF_IRQ_EN: nxt_rdata = {12'h000, irq_en_ff};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= nxt_rdata;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // tally and interrupt
  a_tally_step: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (coll_step && !rd_coll) |=> tally_ff == $past(tally_ff) + 10'h001)
    else $error("tally did not step on collision");

  a_tally_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!coll_step && !rd_coll) |=> $stable(tally_ff))
    else $error("tally moved without collision");

  a_tally_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (coll_step && !rd_coll && tally_ff == 10'h3FF) |=> tally_ff == 10'h000)
    else $error("tally did not wrap");

  a_read_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_coll && !coll_step) |=> tally_ff == 10'h000 && reg_rdata[15:6] == $past(tally_ff))
    else $error("collision read did not return and clear");

  a_coll_id: assert property (@(posedge ref_clk) disable iff (!reset_n)
    rd_coll |=> reg_rdata[5:0] == 6'h12)
    else $error("collision id wrong");

  a_half_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (coll_step && tally_ff == 10'h1FF) |=> irq_stat_ff[0])
    else $error("half count status not set");

  a_half_irq: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (coll_step && tally_ff == 10'h1FF && irq_en_ff[0] && ctrl_ff.collision_overflow_irq_enable
      && !(reg_wr && reg_addr == `LCS_OFF_IRQ_CLR)) |=> ##1 irq)
    else $error("half count interrupt missing");

  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ctrl_ff.collision_overflow_irq_enable |=> !irq)
    else $error("interrupt without overflow enable");

  // line control and port choice
  a_ctrl_id: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_ff.reg_id == 6'h13)
    else $error("line control id bits changed");

  a_port_sel: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_ff.force_attachment_port |=> aui_select && !tp_select)
    else $error("forced AUI not selected");

  a_tp_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ctrl_ff.force_attachment_port && !ctrl_ff.auto_port_select) |=> tp_select && !aui_select)
    else $error("twisted pair not selected");

  a_auto_select: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ctrl_ff.auto_port_select && !ctrl_ff.force_attachment_port)
      |=> aui_select != $past(link_good_ff))
    else $error("auto select ignored link state");

  // status word
  a_stat_id: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT) |=> reg_rdata[5:0] == 6'h14)
    else $error("status id wrong");

  a_aui_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT) |=> reg_rdata[8] == $past(aui_now))
    else $error("AUI flag wrong");

  a_tp_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT) |=> reg_rdata[9] != $past(aui_now))
    else $error("twisted pair flag wrong");

  a_pol_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT)
      |=> reg_rdata[12] != $past(line_in.tp_pol_reversed))
    else $error("polarity flag wrong");

  a_carrier_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT) |=> reg_rdata[14] == $past(rx_carrier))
    else $error("carrier flag wrong");

  a_link_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (reg_rd && reg_addr == `LCS_OFF_LINE_STAT) |=> reg_rdata[7] == $past(link_good_ff))
    else $error("link flag wrong");

  // receive path
  a_pol_corr: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (line_in.tp_pol_reversed && !ctrl_ff.polarity_correction_disable)
      |=> rx_data_corr != $past(line_in.tp_rx_data))
    else $error("reversed data not corrected");

  a_pol_plain: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ctrl_ff.polarity_correction_disable |=> rx_data_corr == $past(line_in.tp_rx_data))
    else $error("data changed with correction disabled");

  a_carrier_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!aui_now && crs_rise) |=> rx_carrier)
    else $error("carrier not raised");

  a_carrier_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!aui_now && crs_rise) |=> rx_carrier [*5])
    else $error("carrier dropped early");

  a_carrier_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!aui_now && !crs_rise && crs_cnt_ff == 4'h0) |=> !rx_carrier)
    else $error("carrier held too long");

  // link watchdog
  a_link_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
    line_in.tp_activity |=> link_good_ff)
    else $error("link not good after activity");

  a_link_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (link_cnt_ff == LINK_LAST && !line_in.tp_activity) |=> !link_good_ff)
    else $error("link not failed after idle span");

  // frame gating and engine selects
  a_rx_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ctrl_ff.serial_receive_enable |=> !rx_frame_start)
    else $error("receive frame admitted while disabled");

  a_tx_gate: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !ctrl_ff.serial_transmit_enable |=> !tx_frame_start)
    else $error("transmit frame admitted while disabled");

  a_backoff_copy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> modified_backoff_sel == $past(ctrl_ff.modified_backoff_enable)
      && single_part_deferral == $past(ctrl_ff.two_part_deferral_disable))
    else $error("backoff or deferral select wrong");

  a_squelch_copy: assert property (@(posedge ref_clk) disable iff (!reset_n)
    1'b1 |=> low_squelch_sel == $past(ctrl_ff.low_receive_squelch))
    else $error("squelch select wrong");
endmodule : lcs_line_ctrl

//--- verif/lcs_medium_model.sv
// network medium model: receive pair, collision pair and polarity
`timescale 1ns/1ps
module lcs_medium_model
  import lcs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic coll_req,
  input wire logic rx_bit,
  input wire logic pol_rev,
  output lcs_line_in_s line_in
);
  initial line_in = '0;
  // a collision shows on both pairs; the block picks by port in use
  always @(posedge ref_clk) begin
    line_in.tp_activity <= coll_req;
    line_in.aui_collision <= coll_req;
    // a reversed pair delivers inverted line data
    line_in.tp_rx_data <= rx_bit ^ pol_rev;
    line_in.tp_pol_reversed <= pol_rev;
    line_in.aui_carrier <= 1'b0;
  end
endmodule : lcs_medium_model

//--- verif/tb_top.sv
// self-checking bench for the line control block
`timescale 1ns/1ps
module tb_top;
  import lcs_pkg::*;
  localparam int LINK = 50;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] reg_addr = '0;
  logic [15:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, tx_req = 1'b0, tx_act = 1'b0;
  logic coll = 1'b0, rx_bit = 1'b0, pol_rev = 1'b0, rd_pend = 1'b0;
  logic [15:0] reg_rdata;
  logic irq, tx_start, rx_carrier, rx_corr, aui_sel, tp_sel, mbo, spd, lsq;
  lcs_line_in_s line_in;
  logic ee_pres = 1'b0, ee_val = 1'b0, rx_req = 1'b0, rx_start;
  logic [15:0] ee_img = '0;
  int n_rx = 0;
  logic [15:0] exp_q[$];
  logic [15:0] pm[3] = '{16'h0100, 16'h0200, 16'h0000};
  logic [15:0] ps[3] = '{16'h1114, 16'h1114, 16'h1214};
  int n_mismatch = 0;
  int tests_run = 0;
  int n_start = 0;
  integer seed = 32'h6798;

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  lcs_medium_model i_lcs_medium_model (.ref_clk(ref_clk), .coll_req(coll),
    .rx_bit(rx_bit), .pol_rev(pol_rev), .line_in(line_in));

  lcs_line_ctrl #(.LINK_CYC(LINK)) i_lcs_line_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .eeprom_present(ee_pres),
    .eeprom_line_ctrl(ee_img), .eeprom_valid(ee_val), .line_in(line_in),
    .tx_frame_req(tx_req), .tx_active(tx_act), .rx_frame_req(rx_req),
    .tx_frame_start(tx_start), .rx_frame_start(rx_start), .rx_carrier(rx_carrier),
    .rx_data_corr(rx_corr), .aui_select(aui_sel), .tp_select(tp_sel),
    .modified_backoff_sel(mbo), .single_part_deferral(spd), .low_squelch_sel(lsq));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test

  // trailing idle edge keeps a strobe from being set twice in one step
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  task automatic hits(input int n);
    repeat (n) begin
      coll <= 1'b1;
      @(posedge ref_clk);
      coll <= 1'b0;
      @(posedge ref_clk);
    end
    repeat (3) @(posedge ref_clk);
  endtask : hits

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rd_pend) begin
      check(reg_rdata, exp_q.pop_front());
    end
    rd_pend <= reg_rd;
    if (tx_start === 1'b1) n_start++;
    if (rx_start === 1'b1) n_rx++;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    integer n;
    logic [15:0] w;
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(12'h112, 16'h0013);
    rd(12'h134, 16'h1214);
    rd(12'h1F0, 16'h0000);
    tx_act <= 1'b1;
    n = 1 + ($unsigned($random(seed)) % 16);
    hits(n);
    rd(12'h132, {n[9:0], 6'h12});
    rd(12'h134, 16'h1294);
    rd(12'h132, 16'h0012);
    tx_act <= 1'b0;
    hits(3);
    rd(12'h132, 16'h0012);
    repeat (LINK + 10) @(posedge ref_clk);
    rd(12'h134, 16'h1214);
    pol_rev <= 1'b1;
    rx_bit <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(16'(rx_corr), 16'h0001);
    rd(12'h134, 16'h0214);
    wr(12'h112, 16'h1013);
    repeat (2) @(posedge ref_clk);
    check(16'(rx_corr), 16'h0000);
    rd(12'h134, 16'h0214);
    pol_rev <= 1'b0;
    rx_bit <= 1'b0;
    wr(12'h112, 16'h0013);
    repeat (6) begin
      rx_bit <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rx_bit <= 1'b0;
      repeat (2) @(posedge ref_clk);
    end
    check(16'(rx_carrier), 16'h0001);
    rd(12'h134, 16'h5214);
    repeat (5) @(posedge ref_clk);
    check(16'(rx_carrier), 16'h0000);
    foreach (pm[i]) begin
      wr(12'h112, pm[i]);
      rd(12'h134, ps[i]);
      check(16'({aui_sel, tp_sel}), 16'({ps[i][8], ps[i][9]}));
    end
    wr(12'h112, 16'h0113);
    tx_act <= 1'b1;
    hits(2);
    rd(12'h132, 16'h0092);
    repeat (4) begin
      w = $random(seed);
      wr(12'h112, w);
      rd(12'h112, (w & 16'h7FC0) | 16'h0013);
      check({13'h0, mbo, spd, lsq}, {13'h0, w[11], w[13], w[14]});
    end
    wr(12'h112, 16'h0413);
    wr(12'h142, 16'h0001);
    hits(511);
    check(16'(irq), 16'h0000);
    hits(1);
    check(16'(irq), 16'h0001);
    rd(12'h140, 16'h0001);
    wr(12'h142, 16'h0000);
    @(posedge ref_clk);
    check(16'(irq), 16'h0000);
    wr(12'h142, 16'h0001);
    wr(12'h144, 16'h0001);
    @(posedge ref_clk);
    check(16'(irq), 16'h0000);
    hits(512);
    rd(12'h132, 16'h0012);
    tx_act <= 1'b0;
    tx_req <= 1'b1;
    rx_req <= 1'b1;
    wr(12'h112, 16'h0013);
    repeat (4) @(posedge ref_clk);
    check(16'(n_start), 16'h0000);
    check(16'(n_rx), 16'h0000);
    wr(12'h112, 16'h00D3);
    repeat (4) @(posedge ref_clk);
    check(16'(n_start != 0), 16'h0001);
    check(16'(n_rx != 0), 16'h0001);
    // second reset with the strap image present
    ee_pres <= 1'b1;
    ee_val <= 1'b1;
    ee_img <= 16'hFFFF;
    tx_req <= 1'b0;
    rx_req <= 1'b0;
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rd(12'h112, 16'h7FD3);
    rd(12'h134, 16'h1114);
    rd(12'h132, 16'h0012);
    wr(12'h112, 16'h0013);
    rd(12'h112, 16'h0013);
    repeat (3) @(posedge ref_clk);
    end_of_test();
  end
endmodule : tb_top
